// ---- rtl/sad_pkg.sv ----
// shared constants, register map and types of the converter sequencer
package sad_pkg;
    // register byte addresses on the wishbone slave
    localparam logic [7:0] SAD_CTRL_ADDR = 8'h00;
    localparam logic [7:0] SAD_INPUT_ADDR = 8'h04;
    localparam logic [7:0] SAD_RLOW_ADDR = 8'h08;
    localparam logic [7:0] SAD_RHIGH_ADDR = 8'h0C;
    localparam logic [7:0] SAD_REG_RESET = 8'h00;
    // converter_control_reg fields
    localparam int SAD_DONE_BIT = 7;
    localparam int SAD_START_BIT = 6;
    localparam int SAD_DAC_BIT = 5;
    localparam int SAD_EN_BIT = 4;
    localparam int SAD_LEFT_ADJUST_BIT = 3;
    localparam int SAD_CKS_LSB = 0;
    localparam int SAD_CKS_W = 3;
    // input_control_reg fields
    localparam int SAD_CONN_BIT = 7;
    localparam int SAD_ISRC_BIT = 6;
    localparam int SAD_TRG_LSB = 4;
    localparam int SAD_TRG_W = 2;
    localparam int SAD_SELECT_A_BIT = 3;
    localparam int SAD_CH_LSB = 0;
    localparam int SAD_CH_W = 3;
    // codes and widths
    localparam int SAD_RES_W = 10;
    localparam int SAD_EXT_W = 6;
    localparam logic [2:0] SAD_CH_INTERNAL = 3'h6;
    localparam logic [1:0] SAD_TRG_SW = 2'h0;
    localparam logic [2:0] SAD_CKS_INTOSC = 3'h0;
    localparam logic [9:0] SAD_SIGN_FLIP = 10'h200;
    // conversion timing in converter clock cycles, and the last count of the oscillator divider
    localparam logic [3:0] SAD_ADC_CYCLES = 4'hD;
    localparam logic [3:0] SAD_DAC_CYCLES = 4'hB;
    localparam logic [3:0] SAD_SAMPLE_CYCLE = 4'h3;
    localparam logic [3:0] SAD_SAR_FIRST = 4'h4;
    localparam logic [3:0] SAD_DAC_BUILD_CYCLE = 4'h2;
    localparam logic [3:0] SAD_DAC_PROP_CYCLE = 4'h7;
    localparam logic [1:0] SAD_OSC_DIV_LAST = 2'h3;

    typedef enum logic [1:0] {SAD_IDLE, SAD_LOAD, SAD_RUN} sad_state_t;

    // everything the analog core and pad logic need, sent as one word
    typedef struct packed {
        logic enable;
        logic dac_mode;
        logic connect;
        logic select_a;
        logic [2:0] channel;
        logic temp_sel;
        logic supply_sel;
        logic sample;
        logic build;
        logic dac_update;
        logic [9:0] code;
        logic port_input_only;
    } sad_ana_t;
endpackage : sad_pkg

// ---- rtl/sad_sequencer.sv ----
// sequencer for the 10-bit successive-approximation adc/dac with wishbone registers
`timescale 1ns/100ps

// Overview of operation
// - adc result is a 10-bit two's complement value, zero difference gives zero
// - differential select low measures against half supply, high measures pin pair
// - channel select routes one of six pins or one of three pin pairs
// - channel six routes an internal source: supply monitor or temperature sensor
// - converter works only while converter enable is set
// - adc conversion lasts 13 converter clocks, input sampled in cycle three
// - adc end sets done flag and loads result, held until next completion
// - done flag reaches the system within one converter and two system clocks
// - in adc mode the result pair is read-only, writes ignored
// - dac mode needs enable and dac bit, output differential around mid supply
// - in dac mode routing settings do nothing, the two output pins forced input-only
// - dac conversion 11 cycles, build from cycle two, outputs update cycle seven
// - dac data pair write-only, copied to buffer at start, held during conversion
// - default converter clock is internal 8 MHz oscillator divided by four
// - alternatively system oscillator through a 7-bit prescaler selected by clock field
// - adc converter clock from the internal oscillator has no fixed relation to the system clock
// - writing start while enabled starts one conversion, bit reads busy until done
// - selected timer overflow starts a conversion, busy set by hardware
// - right adjust sign-extends upper six bits, left adjust zeroes lower six
// - done flag cleared by hardware when the service routine is entered
// - clock code zero is oscillator by four, others divide by 2 to 128
module sad_sequencer
    import sad_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic int_osc_i,
    input wire logic comp_i,
    input wire logic [2:0] timer_ovf_i,
    input wire logic isr_enter_i,
    output sad_ana_t ana_o,
    output logic done_flag_o
);
    logic ack_r;
    logic [31:0] dat_r;
    logic [7:0] ctrl_r;
    logic [7:0] input_r;
    logic [15:0] dac_data_r;
    logic [9:0] result_r;
    logic [9:0] trial_r;
    logic [9:0] trial_nxt;
    logic [9:0] dac_buf_r;
    logic done_r;
    sad_state_t state_r;
    logic [3:0] cyc_r;
    logic run_dac_r;
    logic osc_s1_r;
    logic osc_s2_r;
    logic osc_s3_r;
    logic [1:0] osc_cnt_r;
    logic [6:0] pre_r;
    logic tick_r;
    logic comp_s1_r;
    logic comp_s2_r;
    sad_ana_t ana_r;
    sad_ana_t ana_nxt;

    logic en;
    logic dac_sel;
    logic left_adjust;
    logic [2:0] cks;
    logic [1:0] trigger_select;
    logic wr_now;
    logic wr_sel;
    logic rd_take;
    logic sw_start;
    logic trig_hit;
    logic start_req;
    logic end_conv;
    logic [3:0] last_cyc;
    logic [7:0] mask8;
    logic pre_tick;
    logic osc_tick;
    logic [15:0] res_ext;
    logic [7:0] rd_val;

    assign en = ctrl_r[SAD_EN_BIT];
    assign dac_sel = ctrl_r[SAD_DAC_BIT];
    assign left_adjust = ctrl_r[SAD_LEFT_ADJUST_BIT];
    assign cks = ctrl_r[SAD_CKS_LSB +: SAD_CKS_W];
    assign trigger_select = input_r[SAD_TRG_LSB +: SAD_TRG_W];

    // ---------------- wishbone slave, one wait state ----------------
    assign wr_sel = cyc_i && stb_i && we_i && sel_i[0];
    // writes commit on the edge where the master sees ack
    assign wr_now = wr_sel && ack_r;
    assign rd_take = cyc_i && stb_i && !we_i && !ack_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= cyc_i && stb_i && !ack_r;
        end
    end

    // right adjust sign-extends, left adjust zero-fills the low end
    assign res_ext = left_adjust ? {result_r, {SAD_EXT_W{1'b0}}}
                          : {{SAD_EXT_W{result_r[SAD_RES_W-1]}}, result_r};

    always_comb begin
        rd_val = 8'h00;
        unique case (adr_i)
            SAD_CTRL_ADDR: begin
                rd_val = ctrl_r;
                rd_val[SAD_DONE_BIT] = done_r;
                rd_val[SAD_START_BIT] = (state_r != SAD_IDLE);
            end
            SAD_INPUT_ADDR: rd_val = input_r;
            // the data pair reads zero in dac mode, it is write-only there
            SAD_RLOW_ADDR: rd_val = dac_sel ? 8'h00 : res_ext[7:0];
            SAD_RHIGH_ADDR: rd_val = dac_sel ? 8'h00 : res_ext[15:8];
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (rd_take) begin
            dat_r <= {24'h00_0000, rd_val};
        end else begin
            dat_r <= 32'h0000_0000;
        end
    end

    // ---------------- software registers ----------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= SAD_REG_RESET;
            input_r <= SAD_REG_RESET;
        end else if (wr_now) begin
            if (adr_i == SAD_CTRL_ADDR) begin
                // done and start are kept elsewhere; stored copies stay zero
                ctrl_r <= {2'h0, dat_i[SAD_DAC_BIT:SAD_CKS_LSB]};
            end
            if (adr_i == SAD_INPUT_ADDR) begin
                input_r <= dat_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dac_data_r <= 16'h0000;
        end else if (wr_now && dac_sel) begin
            if (adr_i == SAD_RLOW_ADDR) begin
                dac_data_r[7:0] <= dat_i[7:0];
            end
            if (adr_i == SAD_RHIGH_ADDR) begin
                dac_data_r[15:8] <= dat_i[7:0];
            end
        end
    end

    // ---------------- converter clock ----------------
    // the internal oscillator is asynchronous: two flops before the edge detector
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_s3_r <= 1'b0;
        end else begin
            osc_s1_r <= int_osc_i;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
        end
    end

    assign osc_tick = osc_s2_r && !osc_s3_r && (osc_cnt_r == SAD_OSC_DIV_LAST);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_cnt_r <= 2'h0;
        end else if (osc_s2_r && !osc_s3_r) begin
            osc_cnt_r <= osc_cnt_r + 2'h1;
        end
    end

    // prescaler runs straight off the oscillator clock, not the cpu divider
    assign mask8 = (8'h01 << cks) - 8'h01;
    assign pre_tick = ((pre_r & mask8[6:0]) == mask8[6:0]);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_r <= 7'h00;
        end else begin
            pre_r <= pre_r + 7'h01;
        end
    end

    // converter clock is a one-cycle tick; limited to half the system clock rate
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= (cks == SAD_CKS_INTOSC) ? osc_tick : pre_tick;
        end
    end

    // ---------------- comparator input ----------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            comp_s1_r <= 1'b0;
            comp_s2_r <= 1'b0;
        end else begin
            comp_s1_r <= comp_i;
            comp_s2_r <= comp_s1_r;
        end
    end

    // ---------------- conversion sequencer ----------------
    assign sw_start = wr_now && (adr_i == SAD_CTRL_ADDR) && dat_i[SAD_START_BIT]
                      && dat_i[SAD_EN_BIT];
    assign trig_hit = (trigger_select != SAD_TRG_SW) && timer_ovf_i[trigger_select - 2'h1] && en;
    assign start_req = sw_start || trig_hit;
    assign last_cyc = run_dac_r ? SAD_DAC_CYCLES : SAD_ADC_CYCLES;
    assign end_conv = (state_r == SAD_RUN) && tick_r && (cyc_r == last_cyc) && en;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= SAD_IDLE;
            cyc_r <= 4'h0;
            run_dac_r <= 1'b0;
        end else if (!en && !sw_start) begin
            state_r <= SAD_IDLE;
            cyc_r <= 4'h0;
        end else begin
            unique case (state_r)
                SAD_IDLE: begin
                    if (start_req) begin
                        // dac needs the one-clock buffer copy before its first cycle
                        state_r <= SAD_LOAD;
                        run_dac_r <= sw_start ? dat_i[SAD_DAC_BIT] : dac_sel;
                        cyc_r <= 4'h0;
                    end
                end
                SAD_LOAD: begin
                    state_r <= SAD_RUN;
                end
                SAD_RUN: begin
                    // further start requests fall through unseen here
                    if (tick_r) begin
                        if (cyc_r == last_cyc) begin
                            state_r <= SAD_IDLE;
                            cyc_r <= 4'h0;
                        end else begin
                            cyc_r <= cyc_r + 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dac_buf_r <= 10'h000;
        end else if (state_r == SAD_LOAD) begin
            dac_buf_r <= left_adjust ? dac_data_r[15:6] : dac_data_r[9:0];
        end
    end

    // successive approximation: set the trial bit on entry, drop it if the input is lower
    always_comb begin
        trial_nxt = trial_r;
        if (state_r == SAD_LOAD) begin
            trial_nxt = 10'h000;
        end else if (state_r == SAD_RUN && tick_r && !run_dac_r) begin
            if (cyc_r >= SAD_SAR_FIRST && !comp_s2_r) begin
                trial_nxt[SAD_ADC_CYCLES - cyc_r] = 1'b0;
            end
            if (cyc_r + 4'h1 >= SAD_SAR_FIRST && cyc_r < SAD_ADC_CYCLES) begin
                trial_nxt[SAD_ADC_CYCLES - cyc_r - 4'h1] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trial_r <= 10'h000;
        end else begin
            trial_r <= trial_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_r <= 10'h000;
        end else if (end_conv && !run_dac_r) begin
            // offset-binary trial turned to two's complement
            result_r <= trial_nxt ^ SAD_SIGN_FLIP;
        end
    end

    // set wins over either clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_r <= 1'b0;
        end else if (end_conv) begin
            done_r <= 1'b1;
        end else if (isr_enter_i) begin
            done_r <= 1'b0;
        end else if (wr_now && adr_i == SAD_CTRL_ADDR && !dat_i[SAD_DONE_BIT]) begin
            done_r <= 1'b0;
        end
    end

    // ---------------- analog core controls ----------------
    always_comb begin
        ana_nxt = '0;
        ana_nxt.enable = en;
        ana_nxt.dac_mode = en && dac_sel;
        // routing is dead in dac mode and while the connect bit is open
        ana_nxt.connect = en && !dac_sel && input_r[SAD_CONN_BIT];
        ana_nxt.select_a = ana_nxt.connect && input_r[SAD_SELECT_A_BIT];
        ana_nxt.channel = ana_nxt.connect ? input_r[SAD_CH_LSB +: SAD_CH_W] : 3'h0;
        ana_nxt.temp_sel = ana_nxt.connect && (ana_nxt.channel == SAD_CH_INTERNAL)
                           && input_r[SAD_ISRC_BIT];
        ana_nxt.supply_sel = ana_nxt.connect && (ana_nxt.channel == SAD_CH_INTERNAL)
                             && !input_r[SAD_ISRC_BIT];
        ana_nxt.sample = (state_r == SAD_RUN) && !run_dac_r
                         && (cyc_r == SAD_SAMPLE_CYCLE);
        ana_nxt.build = (state_r == SAD_RUN) && run_dac_r
                        && (cyc_r >= SAD_DAC_BUILD_CYCLE);
        ana_nxt.dac_update = (state_r == SAD_RUN) && run_dac_r
                             && (cyc_r >= SAD_DAC_PROP_CYCLE);
        ana_nxt.code = run_dac_r ? (dac_buf_r ^ SAD_SIGN_FLIP) : trial_r;
        ana_nxt.port_input_only = en && dac_sel;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ana_r <= '0;
        end else begin
            ana_r <= ana_nxt;
        end
    end

    assign ana_o = ana_r;
    assign dat_o = dat_r;
    assign ack_o = ack_r;
    assign done_flag_o = done_r;

    // ---------------- checks ----------------
    a_busy_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        end_conv |=> (state_r == SAD_IDLE) && done_r)
        else $error("busy not cleared at conversion end");

    a_ignore_restart: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == SAD_RUN) && start_req && en && !end_conv |=> state_r == SAD_RUN)
        else $error("running conversion disturbed by start");

    a_sample_third: assert property (@(posedge clk_i) disable iff (rst_i)
        ana_r.sample |-> !run_dac_r && $past(cyc_r) == SAD_SAMPLE_CYCLE)
        else $error("sample outside third cycle");

    a_buffer_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == SAD_RUN) |=> $stable(dac_buf_r))
        else $error("dac buffer changed mid conversion");

    a_result_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !end_conv |=> $stable(result_r))
        else $error("result changed without completion");

    a_disable_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !en && !sw_start |=> state_r == SAD_IDLE)
        else $error("converter ran while disabled");

    a_adc_readonly: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_now && !dac_sel |=> $stable(dac_data_r))
        else $error("data pair written in adc mode");

    a_pins_forced: assert property (@(posedge clk_i) disable iff (rst_i)
        (en && dac_sel) [*2] |-> ana_o.port_input_only && !ana_o.connect)
        else $error("dac pins not forced input-only");

    a_timer_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == SAD_IDLE) && trig_hit |=> state_r == SAD_LOAD ##1 state_r == SAD_RUN)
        else $error("timer overflow did not start conversion");

    a_flag_sync: assert property (@(posedge clk_i) disable iff (rst_i)
        end_conv |-> ##[1:2] done_flag_o)
        else $error("done flag late");

endmodule : sad_sequencer

// ---- tb/sad_analog_model.sv ----
// behavioural analog core: input mux, sample-and-hold, comparator and internal oscillator
`timescale 1ns/100ps
module sad_analog_model
    import sad_pkg::*;
(
    input wire logic clk_i,
    input wire logic [109:0] vin_i,
    input wire sad_ana_t ana_i,
    output logic comp_o,
    output logic osc_o
);
    logic [9:0] level;
    logic [9:0] held_r;
    // slots 0..5 single ended, 6..8 pin pairs, 9 supply monitor, 10 temperature sensor
    always_comb begin
        if (!ana_i.connect) begin
            level = 10'h000;
        end else if (ana_i.channel == SAD_CH_INTERNAL) begin
            level = ana_i.temp_sel ? vin_i[100 +: 10] : vin_i[90 +: 10];
        end else if (ana_i.select_a) begin
            level = vin_i[(6 + ana_i.channel) * 10 +: 10];
        end else begin
            level = vin_i[ana_i.channel * 10 +: 10];
        end
    end
    // left unknown until the first sample, so a missed sample poisons the result
    always @(posedge clk_i) begin
        if (ana_i.sample) begin
            held_r <= level;
        end
    end
    // the level sits half a step above its code, so either comparator reading gives that code
    assign comp_o = (held_r ^ SAD_SIGN_FLIP) >= ana_i.code;
    // runs free whether or not it clocks the converter, phase unrelated to the system clock
    initial begin
        osc_o = 1'b0;
        #7;
        forever #62.5 osc_o = ~osc_o;
    end
endmodule : sad_analog_model

// ---- tb/tb.sv ----
// self-checking bench: register accesses and conversions against the analog model
`timescale 1ns/100ps
module tb
    import sad_pkg::*;
;
    // slot 0 in the low bits: full scale both ways, zero, minus one and mid codes
    localparam logic [109:0] VIN = {10'h30F, 10'h0F0, 10'h155, 10'h2AA, 10'h001, 10'h300,
        10'h100, 10'h3FF, 10'h000, 10'h201, 10'h1FF};
    localparam int TIME_LIMIT = 20000;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, int_osc_i, comp_i, isr_enter_i, done_flag_o, ack_o;
    logic [7:0] adr_i, rd, cfg, hi;
    logic [31:0] dat_i, dat_o;
    logic [3:0] sel_i;
    logic [2:0] timer_ovf_i, ch;
    logic [9:0] v;
    logic [15:0] ex, res;
    sad_ana_t ana_o;
    int err_count = 0, checks_done = 0, cycles = 0, t0, lat;

    sad_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
        .int_osc_i(int_osc_i), .comp_i(comp_i), .timer_ovf_i(timer_ovf_i),
        .isr_enter_i(isr_enter_i), .ana_o(ana_o), .done_flag_o(done_flag_o));
    sad_analog_model u_ana (.clk_i(clk_i), .vin_i(VIN), .ana_i(ana_o), .comp_o(comp_i),
        .osc_o(int_osc_i));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == TIME_LIMIT) begin
            err_count++;
            final_report();
        end
    end

    task automatic final_report();
        if (err_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // one classic cycle: request held until ack is sampled high, read data taken there
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        sel_i <= 4'hF;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h000000, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        rd = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb

    task automatic read_result();
        wb(SAD_RHIGH_ADDR, 1'b0, 8'h00);
        hi = rd;
        wb(SAD_RLOW_ADDR, 1'b0, 8'h00);
        res = {hi, rd};
    endtask : read_result

    // bounds leave room for tick phase and flag synchronisation
    task automatic wait_done(input int n, input int d);
        @(posedge clk_i);
        while (done_flag_o !== 1'b1) @(posedge clk_i);
        lat = cycles - t0;
        checks_done++;
        if (lat < (n - 1) * d || lat > (n + 1) * d + 8) begin
            err_count++;
            $display("FAIL conversion time expected %0d clocks seen %0d", n * d, lat);
        end
    endtask : wait_done

    task automatic convert(input logic [7:0] c, input int n, input int d);
        wb(SAD_CTRL_ADDR, 1'b1, c);
        t0 = cycles;
        wb(SAD_CTRL_ADDR, 1'b0, 8'h00);
        check("busy bit", 16'h0001, 16'(rd[SAD_START_BIT]));
        wait_done(n, d);
        wb(SAD_CTRL_ADDR, 1'b0, 8'h00);
        check("control after done", 16'((c & 8'h3F) | 8'h80), 16'(rd));
    endtask : convert

    task automatic isr();
        @(posedge clk_i);
        isr_enter_i <= 1'b1;
        @(posedge clk_i);
        isr_enter_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("done after isr", 16'h0000, 16'(done_flag_o));
    endtask : isr

    task automatic pulse(input logic [2:0] m);
        @(posedge clk_i);
        timer_ovf_i <= m;
        @(posedge clk_i);
        timer_ovf_i <= 3'h0;
        t0 = cycles;
    endtask : pulse

    initial begin
        {rst_i, cyc_i, stb_i, we_i, isr_enter_i} = 5'h10;
        adr_i = 8'h00;
        dat_i = 32'h00000000;
        sel_i = 4'hF;
        timer_ovf_i = 3'h0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values, the last address is unmapped
        for (int a = 0; a < 5; a++) begin
            wb(8'(a * 4), 1'b0, 8'h00);
            check("reset read", 16'h0000, 16'(rd));
        end
        for (int i = 0; i < 11; i++) begin
            ch = (i < 6) ? 3'(i) : (i < 9) ? 3'(i - 6) : SAD_CH_INTERNAL;
            cfg = {1'b0, i == 10, 2'b00, i > 5 && i < 9, ch};
            wb(SAD_INPUT_ADDR, 1'b1, cfg);
            wb(SAD_INPUT_ADDR, 1'b1, cfg | 8'h80);
            convert(8'h50 | {4'h0, i[0], 3'h0}, 13, 10);
            check("routing", {9'h001, cfg[3], ch, i == 10, i == 9},
                {9'h000, ana_o.connect, ana_o.select_a, ana_o.channel, ana_o.temp_sel,
                ana_o.supply_sel});
            v = VIN[i * 10 +: 10];
            ex = i[0] ? {v, 6'h00} : {{6{v[9]}}, v};
            read_result();
            check("adc result", ex, res);
        end
        check("done flag", 16'h0001, 16'(done_flag_o));
        wb(SAD_RHIGH_ADDR, 1'b1, 8'h12);
        wb(SAD_RLOW_ADDR, 1'b1, 8'h34);
        read_result();
        check("result after write", ex, res);
        isr();
        for (int k = 1; k < 8; k++) convert(8'h50 | 8'(k), 13, 1 << k);
        wb(SAD_CTRL_ADDR, 1'b1, 8'h54);
        t0 = cycles;
        repeat (40) @(posedge clk_i);
        wb(SAD_CTRL_ADDR, 1'b1, 8'h54);
        wait_done(13, 16);
        isr();
        wb(SAD_CTRL_ADDR, 1'b1, 8'h10);
        for (int t = 1; t < 4; t++) begin
            wb(SAD_INPUT_ADDR, 1'b1, 8'hC6 | 8'(t << 4));
            pulse(3'(1 << (t % 3)));
            repeat (3) @(posedge clk_i);
            wb(SAD_CTRL_ADDR, 1'b0, 8'h00);
            check("unselected timer", 16'h0010, 16'(rd));
            pulse(3'(1 << (t - 1)));
            wb(SAD_CTRL_ADDR, 1'b0, 8'h00);
            check("timer busy", 16'h0050, 16'(rd));
            wait_done(13, 10);
            isr();
        end
        wb(SAD_INPUT_ADDR, 1'b1, 8'h0D);
        wb(SAD_INPUT_ADDR, 1'b1, 8'h8D);
        wb(SAD_CTRL_ADDR, 1'b1, 8'h33);
        wb(SAD_RLOW_ADDR, 1'b1, 8'h34);
        wb(SAD_RHIGH_ADDR, 1'b1, 8'h01);
        wb(SAD_CTRL_ADDR, 1'b1, 8'h73);
        t0 = cycles;
        wb(SAD_RLOW_ADDR, 1'b1, 8'hFF);
        wb(SAD_RHIGH_ADDR, 1'b1, 8'h02);
        check("dac early", 16'h3334, {2'h0, ana_o.dac_mode, ana_o.port_input_only,
            ana_o.connect, ana_o.dac_update, ana_o.code});
        repeat (65) @(posedge clk_i);
        check("dac late", 16'h1B34, {3'h0, ana_o.build, ana_o.dac_update, 1'b0,
            ana_o.code});
        wait_done(11, 8);
        read_result();
        check("dac result read", 16'h0000, res);
        // a data write in adc mode must not reach the dac buffer
        wb(SAD_CTRL_ADDR, 1'b1, 8'h13);
        wb(SAD_RLOW_ADDR, 1'b1, 8'h00);
        wb(SAD_CTRL_ADDR, 1'b1, 8'h73);
        t0 = cycles;
        repeat (4) @(posedge clk_i);
        check("dac reload", 16'h00FF, 16'(ana_o.code));
        wait_done(11, 8);
        wb(SAD_CTRL_ADDR, 1'b1, 8'h50);
        repeat (30) @(posedge clk_i);
        wb(SAD_CTRL_ADDR, 1'b1, 8'h00);
        repeat (300) @(posedge clk_i);
        check("abort", 16'h0000, {14'h0000, done_flag_o, ana_o.enable});
        wb(SAD_CTRL_ADDR, 1'b1, 8'h40);
        repeat (300) @(posedge clk_i);
        wb(SAD_CTRL_ADDR, 1'b0, 8'h00);
        check("start disabled", 16'h0000, {7'h00, done_flag_o, rd});
        final_report();
    end
endmodule : tb
